// *** logic/tie_pkg.sv ***
package tie_pkg;
  // Instruction codes, 9 bits
  localparam logic [8:0] OP_NOP = 9'h000;
  localparam logic [8:0] OP_READ_TIMER = 9'h08a;
  localparam logic [8:0] OP_LOAD_TIMER = 9'h085;
  localparam logic [8:0] OP_SKIP_TIMER_FLAG = 9'h08c;
  localparam logic [8:0] OP_RELEASE_SINK = 9'h011;
  localparam logic [8:0] OP_CLEAR_PORT_BIT = 9'h014;
  localparam logic [8:0] OP_SET_PORT_BIT = 9'h015;
  localparam logic [8:0] OP_SKIP_LOW_BIT = 9'h024;
  localparam logic [8:0] OP_SKIP_LOW_BIT_2ND = 9'h02b;
  localparam logic [8:0] OP_WR_TWO_BIT = 9'h084;
  localparam logic [8:0] OP_RD_TWO_BIT = 9'h056;
  localparam logic [8:0] OP_WR_NIB_ONE = 9'h080;
  localparam logic [8:0] OP_RD_NIB_ONE = 9'h028;
  localparam logic [8:0] OP_WR_NIB_TWO = 9'h01b;
  localparam logic [8:0] OP_RD_NIB_TWO = 9'h055;
  localparam logic [8:0] OP_WR_ONE_BIT = 9'h081;
  localparam logic [8:0] OP_RD_ONE_BIT = 9'h057;
  localparam logic [8:0] OP_SET_FLAG_PIN = 9'h082;
  localparam logic [8:0] OP_CLR_FLAG_PIN = 9'h083;
  localparam logic [8:0] OP_SKIP_FLAG_PIN = 9'h08d;
  localparam logic [8:0] OP_BACKUP = 9'h00d;
  localparam logic [8:0] OP_LOAD_GATE_FN = 9'h058;
  localparam logic [8:0] OP_WR_TIMER_CTRL = 9'h086;
  localparam logic [8:0] OP_RD_TIMER_CTRL = 9'h088;
  localparam logic [8:0] OP_WR_WAKEUP_CTRL = 9'h087;
  localparam logic [8:0] OP_RD_WAKEUP_CTRL = 9'h089;
  localparam logic [8:0] OP_WR_PULLUP_CTRL = 9'h08b;
  // Register byte offsets
  localparam logic [7:0] OFS_WORK = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_TIMER = 8'h08;
  localparam logic [7:0] OFS_PORTS = 8'h0c;
  localparam logic [7:0] OFS_CTRL = 8'h10;
  // Field positions
  localparam int STAT_BACKUP_BIT = 1;
  localparam int STAT_PC_LSB = 16;
  localparam int TCTL_RUN_BIT = 2;
  // Reset values
  localparam logic [3:0] RST_SINK = 4'hf;
  localparam logic [3:0] RST_NIBBLE = 4'h0;
  localparam logic [3:0] RST_CTRL = 4'h0;
  localparam logic [7:0] RST_TIMER = 8'hff;
  localparam logic [10:0] RST_PC = 11'h000;
  // Prescaler period in clock cycles
  localparam int PRESCALE_CYCLES = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    TIE_ST_FETCH = 2'h1,
    TIE_ST_SECOND = 2'h2
  } tie_state_t;
endpackage

// *** logic/tie_sync.sv ***
`timescale 1ns/1ps
// Two-stage synchroniser for pin inputs
module tie_sync #(
  parameter int WIDTH = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // First stage feeds only the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule

// *** logic/tie_exec.sv ***
// The AXI4-Lite register port and the address map were decided locally.
`timescale 1ns/1ps
module tie_exec #(
  parameter int PRESCALE = tie_pkg::PRESCALE_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [8:0] instr_word,
  input wire logic instr_valid,
  output logic instr_ready,
  output logic [10:0] pc_out,
  output logic [3:0] sink_port_out,
  output logic [3:0] sink_port_oe,
  output logic [1:0] two_bit_port_out,
  input wire logic [1:0] two_bit_port_in,
  output logic [3:0] nib_one_port_out,
  input wire logic [3:0] nib_one_port_in,
  output logic [3:0] nib_two_port_out,
  input wire logic [3:0] nib_two_port_in,
  output logic one_bit_port_out,
  input wire logic one_bit_port_in,
  output logic output_flag_pin,
  output logic backup_state,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  tie_pkg::tie_state_t state_ff, nxt_state;
  logic [10:0] pc_ff, nxt_pc;
  logic [3:0] work_ff, nxt_work, high_ff, nxt_high;
  logic [1:0] sel_ff, nxt_sel;
  logic [7:0] timer_ff, nxt_timer, reload_ff, nxt_reload;
  logic tflag_ff, nxt_tflag, skip_ff, nxt_skip, dead_ff, nxt_dead;
  logic [3:0] sink_ff, nxt_sink, nib1_ff, nxt_nib1, nib2_ff, nxt_nib2;
  logic [1:0] two_ff, nxt_two, gate_ff, nxt_gate;
  logic one_ff, nxt_one, flagpin_ff, nxt_flagpin, backup_ff, nxt_backup;
  logic [3:0] tctl_ff, nxt_tctl, wake_ff, nxt_wake, pull_ff, nxt_pull;
  logic [7:0] pre_ff, nxt_pre;
  logic [10:0] pins_s;
  logic take, exec, tick;
  logic aw_ff, nxt_aw, w_ff, nxt_w, bv_ff, nxt_bv, rv_ff, nxt_rv;
  logic [7:0] awa_ff, nxt_awa;
  logic [31:0] wd_ff, nxt_wd, rd_ff, nxt_rd;
  logic [3:0] ws_ff, nxt_ws;
  logic [1:0] br_ff, nxt_br, rr_ff, nxt_rr;
  logic do_wr;

  tie_sync #(.WIDTH(11)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({one_bit_port_in, two_bit_port_in, nib_two_port_in, nib_one_port_in}),
    .sync_out(pins_s)
  );

  // Fetch handshake; back-up state stalls the fetch
  assign instr_ready = !backup_ff;
  assign take = instr_valid && instr_ready;
  assign exec = take && !skip_ff && state_ff == tie_pkg::TIE_ST_FETCH;
  assign tick = tctl_ff[tie_pkg::TCTL_RUN_BIT] && pre_ff == 8'(PRESCALE - 1);
  assign do_wr = aw_ff && w_ff && !bv_ff;

  // Instruction execution and timer
  always_comb begin
    nxt_state = state_ff;
    nxt_pc = pc_ff;
    nxt_work = work_ff;
    nxt_high = high_ff;
    nxt_sel = sel_ff;
    nxt_timer = timer_ff;
    nxt_reload = reload_ff;
    nxt_tflag = tflag_ff;
    nxt_skip = skip_ff;
    nxt_dead = dead_ff;
    nxt_sink = sink_ff;
    nxt_nib1 = nib1_ff;
    nxt_nib2 = nib2_ff;
    nxt_two = two_ff;
    nxt_gate = gate_ff;
    nxt_one = one_ff;
    nxt_flagpin = flagpin_ff;
    nxt_backup = backup_ff;
    nxt_tctl = tctl_ff;
    nxt_wake = wake_ff;
    nxt_pull = pull_ff;
    nxt_pre = tctl_ff[tie_pkg::TCTL_RUN_BIT] ? (tick ? 8'h00 : pre_ff + 8'h01) : 8'h00;
    // Software access to working state
    if (do_wr && ws_ff[0] && awa_ff == tie_pkg::OFS_WORK) begin
      nxt_work = wd_ff[3:0];
      nxt_high = wd_ff[7:4];
      nxt_sel = wd_ff[9:8];
    end
    if (do_wr && ws_ff[0] && awa_ff == tie_pkg::OFS_STATUS && wd_ff[tie_pkg::STAT_BACKUP_BIT]) begin
      nxt_backup = 1'b0;
    end
    // Down-count; underflow reloads and raises the flag
    if (tick) begin
      nxt_timer = (timer_ff == 8'h00) ? reload_ff : timer_ff - 8'h01;
    end
    if (take) begin
      nxt_pc = pc_ff + 11'h001;
      nxt_skip = 1'b0;
      if (state_ff == tie_pkg::TIE_ST_SECOND) begin
        nxt_state = tie_pkg::TIE_ST_FETCH;
        if (!dead_ff && instr_word == tie_pkg::OP_SKIP_LOW_BIT_2ND) begin
          nxt_skip = !sink_ff[sel_ff];
        end
      end else if (skip_ff) begin
        nxt_dead = 1'b1;
        if (instr_word == tie_pkg::OP_SKIP_LOW_BIT) begin
          nxt_state = tie_pkg::TIE_ST_SECOND;
        end
      end
    end
    if (exec) begin
      nxt_dead = 1'b0;
      unique case (instr_word)
        tie_pkg::OP_READ_TIMER: begin
          nxt_high = timer_ff[7:4];
          nxt_work = timer_ff[3:0];
        end
        tie_pkg::OP_LOAD_TIMER: begin
          nxt_timer = {high_ff, work_ff};
          nxt_reload = {high_ff, work_ff};
        end
        tie_pkg::OP_SKIP_TIMER_FLAG: begin
          if (tflag_ff) begin
            nxt_skip = 1'b1;
            nxt_tflag = 1'b0;
          end
        end
        tie_pkg::OP_RELEASE_SINK: nxt_sink = 4'hf;
        tie_pkg::OP_CLEAR_PORT_BIT: nxt_sink[sel_ff] = 1'b0;
        tie_pkg::OP_SET_PORT_BIT: nxt_sink[sel_ff] = 1'b1;
        tie_pkg::OP_SKIP_LOW_BIT: nxt_state = tie_pkg::TIE_ST_SECOND;
        tie_pkg::OP_WR_TWO_BIT: nxt_two = work_ff[1:0];
        tie_pkg::OP_RD_TWO_BIT: nxt_work = {2'h0, pins_s[9:8]};
        tie_pkg::OP_WR_ONE_BIT: nxt_one = work_ff[0];
        tie_pkg::OP_RD_ONE_BIT: nxt_work = {3'h0, pins_s[10]};
        tie_pkg::OP_WR_NIB_ONE: nxt_nib1 = work_ff;
        tie_pkg::OP_RD_NIB_ONE: nxt_work = pins_s[3:0];
        tie_pkg::OP_WR_NIB_TWO: nxt_nib2 = work_ff;
        tie_pkg::OP_RD_NIB_TWO: nxt_work = pins_s[7:4];
        tie_pkg::OP_SET_FLAG_PIN: nxt_flagpin = 1'b1;
        tie_pkg::OP_CLR_FLAG_PIN: nxt_flagpin = 1'b0;
        tie_pkg::OP_SKIP_FLAG_PIN: nxt_skip = flagpin_ff;
        tie_pkg::OP_BACKUP: nxt_backup = 1'b1;
        tie_pkg::OP_LOAD_GATE_FN: nxt_gate = work_ff[1:0];
        tie_pkg::OP_WR_TIMER_CTRL: nxt_tctl = work_ff;
        tie_pkg::OP_RD_TIMER_CTRL: nxt_work = tctl_ff;
        tie_pkg::OP_WR_WAKEUP_CTRL: nxt_wake = work_ff;
        tie_pkg::OP_RD_WAKEUP_CTRL: nxt_work = wake_ff;
        tie_pkg::OP_WR_PULLUP_CTRL: nxt_pull = work_ff;
        default: nxt_pc = pc_ff + 11'h001; // No-op and codes of other groups
      endcase
    end
    // Hardware set wins over the instruction's clear
    if (tick && timer_ff == 8'h00) begin
      nxt_tflag = 1'b1;
    end
  end

  // Execution registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= tie_pkg::TIE_ST_FETCH;
      pc_ff <= tie_pkg::RST_PC;
      work_ff <= 4'h0;
      high_ff <= 4'h0;
      sel_ff <= 2'h0;
      timer_ff <= tie_pkg::RST_TIMER;
      reload_ff <= tie_pkg::RST_TIMER;
      tflag_ff <= 1'b0;
      skip_ff <= 1'b0;
      dead_ff <= 1'b0;
      sink_ff <= tie_pkg::RST_SINK;
      nib1_ff <= tie_pkg::RST_NIBBLE;
      nib2_ff <= tie_pkg::RST_NIBBLE;
      two_ff <= 2'h0;
      gate_ff <= 2'h0;
      one_ff <= 1'b0;
      flagpin_ff <= 1'b0;
      backup_ff <= 1'b0;
      tctl_ff <= tie_pkg::RST_CTRL;
      wake_ff <= tie_pkg::RST_CTRL;
      pull_ff <= tie_pkg::RST_CTRL;
      pre_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      pc_ff <= nxt_pc;
      work_ff <= nxt_work;
      high_ff <= nxt_high;
      sel_ff <= nxt_sel;
      timer_ff <= nxt_timer;
      reload_ff <= nxt_reload;
      tflag_ff <= nxt_tflag;
      skip_ff <= nxt_skip;
      dead_ff <= nxt_dead;
      sink_ff <= nxt_sink;
      nib1_ff <= nxt_nib1;
      nib2_ff <= nxt_nib2;
      two_ff <= nxt_two;
      gate_ff <= nxt_gate;
      one_ff <= nxt_one;
      flagpin_ff <= nxt_flagpin;
      backup_ff <= nxt_backup;
      tctl_ff <= nxt_tctl;
      wake_ff <= nxt_wake;
      pull_ff <= nxt_pull;
      pre_ff <= nxt_pre;
    end
  end

  // Pin outputs; sink bits drive low only when 0
  assign pc_out = pc_ff;
  assign sink_port_out = sink_ff;
  assign sink_port_oe = ~sink_ff;
  assign two_bit_port_out = two_ff;
  assign nib_one_port_out = nib1_ff;
  assign nib_two_port_out = nib2_ff;
  assign one_bit_port_out = one_ff;
  assign output_flag_pin = flagpin_ff;
  assign backup_state = backup_ff;

  // AXI4-Lite slave, one write and one read at a time
  always_comb begin
    nxt_aw = aw_ff;
    nxt_w = w_ff;
    nxt_awa = awa_ff;
    nxt_wd = wd_ff;
    nxt_ws = ws_ff;
    nxt_bv = bv_ff;
    nxt_br = br_ff;
    nxt_rv = rv_ff;
    nxt_rd = rd_ff;
    nxt_rr = rr_ff;
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_aw = 1'b1;
      nxt_awa = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_w = 1'b1;
      nxt_wd = s_axi_wdata;
      nxt_ws = s_axi_wstrb;
    end
    if (do_wr) begin
      nxt_aw = 1'b0;
      nxt_w = 1'b0;
      nxt_bv = 1'b1;
      nxt_br = (awa_ff == tie_pkg::OFS_WORK || awa_ff == tie_pkg::OFS_STATUS) ? tie_pkg::RESP_OKAY
               : tie_pkg::RESP_SLVERR;
    end
    if (bv_ff && s_axi_bready) begin
      nxt_bv = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_rv = 1'b1;
      nxt_rr = tie_pkg::RESP_OKAY;
      unique case (s_axi_araddr[7:0])
        tie_pkg::OFS_WORK: nxt_rd = {22'h0, sel_ff, high_ff, work_ff};
        tie_pkg::OFS_STATUS: nxt_rd = {5'h0, pc_ff, 12'h0, skip_ff, flagpin_ff, backup_ff, tflag_ff};
        tie_pkg::OFS_TIMER: nxt_rd = {16'h0, reload_ff, timer_ff};
        tie_pkg::OFS_PORTS: nxt_rd = {17'h0, one_ff, two_ff, nib2_ff, nib1_ff, sink_ff};
        tie_pkg::OFS_CTRL: nxt_rd = {16'h0, pull_ff, wake_ff, tctl_ff, 2'h0, gate_ff};
        default: begin
          nxt_rd = 32'h0000_0000;
          nxt_rr = tie_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rv_ff && s_axi_rready) begin
      nxt_rv = 1'b0;
    end
  end

  // Bus registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awa_ff <= 8'h00;
      wd_ff <= 32'h0000_0000;
      ws_ff <= 4'h0;
      bv_ff <= 1'b0;
      br_ff <= 2'h0;
      rv_ff <= 1'b0;
      rd_ff <= 32'h0000_0000;
      rr_ff <= 2'h0;
    end else begin
      aw_ff <= nxt_aw;
      w_ff <= nxt_w;
      awa_ff <= nxt_awa;
      wd_ff <= nxt_wd;
      ws_ff <= nxt_ws;
      bv_ff <= nxt_bv;
      br_ff <= nxt_br;
      rv_ff <= nxt_rv;
      rd_ff <= nxt_rd;
      rr_ff <= nxt_rr;
    end
  end

  assign s_axi_awready = !aw_ff && !bv_ff;
  assign s_axi_wready = !w_ff && !bv_ff;
  assign s_axi_bvalid = bv_ff;
  assign s_axi_bresp = br_ff;
  assign s_axi_arready = !rv_ff;
  assign s_axi_rvalid = rv_ff;
  assign s_axi_rdata = rd_ff;
  assign s_axi_rresp = rr_ff;

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_READ_TIMER: assert property (exec && instr_word == tie_pkg::OP_READ_TIMER |=>
    {high_ff, work_ff} == $past(timer_ff)) else $error("read timer copy wrong");
  AST_LOAD_TIMER: assert property (exec && instr_word == tie_pkg::OP_LOAD_TIMER |=>
    timer_ff == reload_ff && timer_ff == $past({high_ff, work_ff})) else $error("load timer wrong");
  AST_TIMER_SKIP: assert property (exec && instr_word == tie_pkg::OP_SKIP_TIMER_FLAG && tflag_ff
    && !tick |=> skip_ff && !tflag_ff) else $error("timer flag skip wrong");
  AST_RELEASE: assert property (exec && instr_word == tie_pkg::OP_RELEASE_SINK |=>
    sink_port_oe == 4'h0) else $error("sink not released");
  AST_CLR_BIT: assert property (exec && instr_word == tie_pkg::OP_CLEAR_PORT_BIT |=>
    !sink_ff[$past(sel_ff)] && sink_port_oe[$past(sel_ff)]) else $error("port bit not cleared");
  AST_SKIP_LOW: assert property (exec && instr_word == tie_pkg::OP_SKIP_LOW_BIT ##1
    take && instr_word == tie_pkg::OP_SKIP_LOW_BIT_2ND |=> skip_ff == !$past(sink_ff[sel_ff], 1))
    else $error("low bit skip wrong");
  AST_RD_TWO: assert property (exec && instr_word == tie_pkg::OP_RD_TWO_BIT |=>
    work_ff == {2'h0, $past(pins_s[9:8])}) else $error("two-bit read wrong");
  AST_FLAG_PIN: assert property (exec && instr_word == tie_pkg::OP_SET_FLAG_PIN |=>
    output_flag_pin) else $error("flag pin not set");
  AST_BACKUP: assert property (exec && instr_word == tie_pkg::OP_BACKUP |=>
    backup_state && !instr_ready) else $error("backup not entered");
  AST_PC_STEP: assert property (take |=> pc_out == $past(pc_out) + 11'h001)
    else $error("pc did not advance");

  COV_SKIP_LOW: cover property (exec && instr_word == tie_pkg::OP_SKIP_LOW_BIT ##1 take ##1 skip_ff);
  COV_TFLAG: cover property (tflag_ff ##1 exec && instr_word == tie_pkg::OP_SKIP_TIMER_FLAG);
  COV_BACKUP: cover property (backup_ff ##1 !backup_ff);
endmodule

// *** verification/tie_prog_mem.sv ***
`timescale 1ns/1ps
// Program memory model: serves the word addressed by the program counter
module tie_prog_mem (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [10:0] pc,
  input wire logic go,
  input wire logic slow,
  input wire logic [10:0] stop_pc,
  output logic [8:0] instr_word,
  output logic instr_valid
);
  logic [8:0] mem [0:2047];
  logic gap_ff;
  // Empty memory reads as no-operation
  initial begin
    for (int i = 0; i < 2048; i++) begin
      mem[i] = tie_pkg::OP_NOP;
    end
  end
  // Slow mode leaves every other cycle without a word
  always_ff @(posedge aclk) begin
    gap_ff <= aresetn && slow && !gap_ff;
  end
  assign instr_valid = go && (pc != stop_pc) && !gap_ff;
  // Between fetches the word lines show junk, never the last word
  assign instr_word = instr_valid ? mem[pc] : ~mem[pc];
endmodule

// *** verification/test_timer_io_instruction_exec.sv ***
`timescale 1ns/1ps
module test_timer_io_instruction_exec;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [8:0] instr_word;
  logic instr_valid, instr_ready, one_bit_port_out, one_bit_port_in, output_flag_pin, backup_state;
  logic [10:0] pc_out, stop_pc;
  logic [3:0] sink_port_out, sink_port_oe, nib_one_port_out, nib_one_port_in, nib_two_port_out, nib_two_port_in;
  logic [1:0] two_bit_port_out, two_bit_port_in, s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb, s;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, go, slow;
  logic [8:0] rop [4];
  logic [3:0] rexp [4];
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0;
  int epc = 0;

  always #10 aclk = ~aclk;

  tie_exec #(.PRESCALE(2)) tie_exec_inst (.aclk, .aresetn, .instr_word, .instr_valid, .instr_ready, .pc_out,
    .sink_port_out, .sink_port_oe, .two_bit_port_out, .two_bit_port_in, .nib_one_port_out, .nib_one_port_in,
    .nib_two_port_out, .nib_two_port_in, .one_bit_port_out, .one_bit_port_in, .output_flag_pin, .backup_state,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  tie_prog_mem tie_prog_mem_inst (.aclk, .aresetn, .pc(pc_out), .go, .slow, .stop_pc, .instr_word, .instr_valid);

  // Closing report and verdict
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      complete_run();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Bus write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // Bus read
  task automatic rdr(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Preset working registers, then run n words from the current program counter
  task automatic exec(input logic [9:0] work, input logic [8:0] w0, input logic [8:0] w1, input logic [8:0] w2,
                      input int n);
    wr(tie_pkg::OFS_WORK, {22'h0, work});
    @(posedge aclk);
    tie_prog_mem_inst.mem[pc_out] = w0;
    tie_prog_mem_inst.mem[pc_out + 11'h1] = w1;
    tie_prog_mem_inst.mem[pc_out + 11'h2] = w2;
    stop_pc <= pc_out + 11'(n);
    go <= 1'b1;
    do @(posedge aclk); while (pc_out != stop_pc);
    go <= 1'b0;
    epc = epc + n;
    chk("pc", 32'(epc), {21'h0, pc_out});
  endtask

  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, go, slow} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    s_axi_wstrb = 4'hf;
    stop_pc = 11'h000;
    two_bit_port_in = 2'h2;
    nib_one_port_in = 4'h6;
    nib_two_port_in = 4'h9;
    one_bit_port_in = 1'b1;
    rop = '{tie_pkg::OP_RD_TWO_BIT, tie_pkg::OP_RD_NIB_ONE, tie_pkg::OP_RD_NIB_TWO, tie_pkg::OP_RD_ONE_BIT};
    rexp = '{4'h2, 4'h6, 4'h9, 4'h1};
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    // Timer load and read back
    exec(10'h0a5, tie_pkg::OP_LOAD_TIMER, tie_pkg::OP_NOP, tie_pkg::OP_NOP, 2);
    rdr(tie_pkg::OFS_TIMER);
    chk("timer and reload", 32'h0000a5a5, rd);
    exec(10'h000, tie_pkg::OP_READ_TIMER, tie_pkg::OP_NOP, tie_pkg::OP_NOP, 1);
    rdr(tie_pkg::OFS_WORK);
    chk("work after timer read", 32'h000000a5, rd);
    $display("test timer done");
    // Sink port bit control and skip on low bit
    for (int y = 0; y < 4; y++) begin
      exec({2'(y), 8'h00}, tie_pkg::OP_CLEAR_PORT_BIT, tie_pkg::OP_NOP, tie_pkg::OP_NOP, 1);
      s = 4'(4'hf << (y + 1));
      chk("sink bits", {24'h0, ~s, s}, {24'h0, sink_port_oe, sink_port_out});
    end
    exec(10'h209, tie_pkg::OP_SKIP_LOW_BIT, tie_pkg::OP_SKIP_LOW_BIT_2ND, tie_pkg::OP_WR_NIB_ONE, 3);
    chk("nib one after skip", 32'h0, {28'h0, nib_one_port_out});
    exec(10'h200, tie_pkg::OP_SET_PORT_BIT, tie_pkg::OP_NOP, tie_pkg::OP_NOP, 1);
    chk("sink set bit", 32'h4, {28'h0, sink_port_out});
    exec(10'h209, tie_pkg::OP_SKIP_LOW_BIT, tie_pkg::OP_SKIP_LOW_BIT_2ND, tie_pkg::OP_WR_NIB_ONE, 3);
    chk("nib one no skip", 32'h9, {28'h0, nib_one_port_out});
    exec(10'h000, tie_pkg::OP_RELEASE_SINK, tie_pkg::OP_NOP, tie_pkg::OP_NOP, 1);
    chk("sink released", 32'h0f, {24'h0, sink_port_oe, sink_port_out});
    $display("test sink port done");
    // Port transfers with a slow program memory
    @(posedge aclk);
    slow <= 1'b1;
    exec(10'h00b, tie_pkg::OP_WR_TWO_BIT, tie_pkg::OP_WR_NIB_ONE, tie_pkg::OP_WR_NIB_TWO, 3);
    exec(10'h00b, tie_pkg::OP_WR_ONE_BIT, tie_pkg::OP_NOP, tie_pkg::OP_NOP, 1);
    chk("port outputs", {21'h0, 11'h777}, {21'h0, two_bit_port_out, nib_one_port_out, nib_two_port_out,
        one_bit_port_out});
    for (int i = 0; i < 4; i++) begin
      exec(10'h00f, rop[i], tie_pkg::OP_NOP, tie_pkg::OP_NOP, 1);
      rdr(tie_pkg::OFS_WORK);
      chk("work after port read", {28'h0, rexp[i]}, {28'h0, rd[3:0]});
    end
    slow <= 1'b0;
    $display("test ports done");
    // Flag pin set, clear and skip
    exec(10'h003, tie_pkg::OP_SET_FLAG_PIN, tie_pkg::OP_SKIP_FLAG_PIN, tie_pkg::OP_WR_NIB_TWO, 3);
    chk("flag pin and nib two", 32'h1b, {27'h0, output_flag_pin, nib_two_port_out});
    exec(10'h003, tie_pkg::OP_CLR_FLAG_PIN, tie_pkg::OP_SKIP_FLAG_PIN, tie_pkg::OP_WR_NIB_TWO, 3);
    chk("flag pin and nib two", 32'h03, {27'h0, output_flag_pin, nib_two_port_out});
    $display("test flag pin done");
    // Control register transfers
    exec(10'h007, tie_pkg::OP_LOAD_GATE_FN, tie_pkg::OP_NOP, tie_pkg::OP_NOP, 1);
    exec(10'h009, tie_pkg::OP_WR_TIMER_CTRL, tie_pkg::OP_NOP, tie_pkg::OP_NOP, 1);
    exec(10'h006, tie_pkg::OP_WR_WAKEUP_CTRL, tie_pkg::OP_NOP, tie_pkg::OP_NOP, 1);
    exec(10'h00c, tie_pkg::OP_WR_PULLUP_CTRL, tie_pkg::OP_NOP, tie_pkg::OP_NOP, 1);
    rdr(tie_pkg::OFS_CTRL);
    chk("control registers", 32'h0000c693, rd);
    exec(10'h000, tie_pkg::OP_RD_TIMER_CTRL, tie_pkg::OP_NOP, tie_pkg::OP_NOP, 1);
    rdr(tie_pkg::OFS_WORK);
    chk("work from timer ctrl", 32'h9, {28'h0, rd[3:0]});
    exec(10'h000, tie_pkg::OP_RD_WAKEUP_CTRL, tie_pkg::OP_NOP, tie_pkg::OP_NOP, 1);
    rdr(tie_pkg::OFS_WORK);
    chk("work from wakeup ctrl", 32'h6, {28'h0, rd[3:0]});
    $display("test control done");
    // Timer underflow flag and its skip
    exec(10'h001, tie_pkg::OP_LOAD_TIMER, tie_pkg::OP_NOP, tie_pkg::OP_NOP, 1);
    exec(10'h004, tie_pkg::OP_WR_TIMER_CTRL, tie_pkg::OP_NOP, tie_pkg::OP_NOP, 1);
    rd = 32'h0;
    for (int k = 0; k < 20 && !rd[0]; k++) begin
      rdr(tie_pkg::OFS_STATUS);
    end
    exec(10'h000, tie_pkg::OP_WR_TIMER_CTRL, tie_pkg::OP_NOP, tie_pkg::OP_NOP, 1);
    exec(10'h000, tie_pkg::OP_SKIP_TIMER_FLAG, tie_pkg::OP_WR_ONE_BIT, tie_pkg::OP_NOP, 2);
    rdr(tie_pkg::OFS_STATUS);
    chk("one bit and timer flag", 32'h2, {30'h0, one_bit_port_out, rd[0]});
    exec(10'h000, tie_pkg::OP_SKIP_TIMER_FLAG, tie_pkg::OP_WR_ONE_BIT, tie_pkg::OP_NOP, 2);
    chk("one bit no skip", 32'h0, {31'h0, one_bit_port_out});
    $display("test timer flag done");
    // Back-up entry, exit and unmapped address
    exec(10'h000, tie_pkg::OP_BACKUP, tie_pkg::OP_NOP, tie_pkg::OP_NOP, 1);
    chk("backup and ready", 32'h2, {30'h0, backup_state, instr_ready});
    wr(tie_pkg::OFS_STATUS, 32'h2);
    chk("backup exit", 32'h1, {30'h0, backup_state, instr_ready});
    rdr(8'h20);
    chk("unmapped read response", 32'(tie_pkg::RESP_SLVERR), {30'h0, resp});
    $display("test backup done");
    complete_run();
  end
endmodule
